// ==== logic/ild_defs.svh ====
// offsets, field positions and reset values of the level and dma routing block
`ifndef ILD_DEFS_SVH
`define ILD_DEFS_SVH

// register byte addresses
`define ILD_CFG_ADDR 32'hffffe014
`define ILD_STAT_ADDR 32'hffffe100
`define ILD_EN_ADDR 32'hffffe104
`define ILD_CLR_ADDR 32'hffffe108
`define ILD_LIVE_ADDR 32'hffffe10c

// slot layout inside the configuration word
`define ILD_SLOT_W 8
`define ILD_NSLOT 4
`define ILD_SEL_LSB 0
`define ILD_DMA_BIT 3
`define ILD_TRIG_LSB 4
`define ILD_SRC20_DMA 3
`define ILD_SRC21_DMA 11
`define ILD_SRC22_DMA 19
`define ILD_SRC23_DMA 27

// writable bits of the configuration word, the rest read as zero
`define ILD_CFG_MASK 32'h3f3f3f3f
`define ILD_CFG_RST 32'h00000000

// trigger modes
`define ILD_TRIG_LOW 2'h0
`define ILD_TRIG_HIGH 2'h1
`define ILD_TRIG_FALL 2'h2
`define ILD_TRIG_RISE 2'h3

// status layout: invalid selector, early trigger mode, dma overrun
`define ILD_ST_BAD_LSB 0
`define ILD_ST_MODE_LSB 4
`define ILD_ST_OVR_LSB 8
`define ILD_ST_W 12
`define ILD_ST_RST 12'h000

`endif

// ==== logic/ild_pkg.sv ====
// types shared by the level and dma routing block
`default_nettype none
package ild_pkg;

    // one 8-bit slot of the configuration word
    typedef struct packed {
        logic [1:0] pad;
        logic [1:0] trig;
        logic dma;
        logic [2:0] sel;
    } slot_cfg_t;

    // interrupt request towards the priority resolver
    typedef struct packed {
        logic req;
        logic [2:0] level;
    } slot_out_t;

endpackage
`default_nettype wire

// ==== logic/ild_slot.sv ====
// one interrupt source slot: trigger detection and level or dma steering
`include "ild_defs.svh"
`default_nettype none
module ild_slot (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic src,
    input wire ild_pkg::slot_cfg_t cfg,
    output var ild_pkg::slot_out_t irq,
    output var logic [3:0] dma_ch,
    output wire logic mode_warn
);

    logic prev;
    logic hit;
    logic enabled;
    logic next_req;
    logic [2:0] next_level;
    logic [3:0] next_dma;

    // active state of the request for each trigger mode
    function automatic logic detect(input logic [1:0] mode, input logic cur, input logic old);
        logic res;
        res = 1'b0;
        unique case (mode)
            `ILD_TRIG_LOW: res = ~cur;
            `ILD_TRIG_HIGH: res = cur;
            `ILD_TRIG_FALL: res = old & ~cur;
            `ILD_TRIG_RISE: res = ~old & cur;
        endcase
        return res;
    endfunction

    // steering decode
    assign hit = detect(cfg.trig, src, prev);
    assign enabled = cfg.dma | (cfg.sel != 3'h0);
    assign next_req = hit & ~cfg.dma & (cfg.sel != 3'h0);
    assign next_level = cfg.dma ? 3'h0 : cfg.sel;
    // selector codes with the top bit set name no channel and start nothing
    assign next_dma = (hit & cfg.dma & ~cfg.sel[2]) ? (4'h1 << cfg.sel[1:0]) : 4'h0;
    // a live request in any trigger mode other than rising edge is worth a warning
    assign mode_warn = hit & enabled & (cfg.trig != `ILD_TRIG_RISE);

    // previous input for edge modes, registered irq and dma_ch outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev <= 1'b0;
            irq <= '0;
            dma_ch <= 4'h0;
        end else begin
            prev <= src;
            irq <= '{req: next_req, level: next_level};
            dma_ch <= next_dma;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_rise_dma0;
        (cfg.trig == `ILD_TRIG_RISE && cfg.dma && cfg.sel == 3'h0 && !src) ##1 (src && $stable(cfg));
    endsequence

    AST_DISABLED_SILENT: assert property (!cfg.dma && cfg.sel == 3'h0 |=> !irq.req)
        else $error("disabled slot raised a request");
    AST_LEVEL_FOLLOWS: assert property (!cfg.dma |=> irq.level == $past(cfg.sel))
        else $error("level output differs from the programmed level");
    AST_DMA_NO_IRQ: assert property (cfg.dma |=> !irq.req && irq.level == 3'h0)
        else $error("dma routed slot still requests an interrupt");
    AST_RISE_DMA0: assert property (s_rise_dma0 |=> dma_ch == 4'h1)
        else $error("rising edge did not trigger channel 0");
    AST_INVALID_SEL: assert property (cfg.dma && cfg.sel[2] |=> dma_ch == 4'h0)
        else $error("invalid channel selector started a transfer");

endmodule
`default_nettype wire

// ==== logic/ild_top.sv ====
// configuration register for sources 20 to 23 with apb slave, dma hold and event flags
//
// Register access over APB was left to the implementer.
`include "ild_defs.svh"
`default_nettype none
module ild_top (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output var logic [31:0] PRDATA,
    output wire logic PREADY,
    output wire logic PSLVERR,
    input wire logic [3:0] SRC_IRQ,
    output wire ild_pkg::slot_out_t [3:0] IRQ_OUT,
    output var logic [3:0] DMA_REQ,
    input wire logic [3:0] DMA_ACK,
    output var logic INT_OUT
);

    // software visible state
    logic [31:0] cfg;
    logic [`ILD_ST_W-1:0] stat;
    logic [`ILD_ST_W-1:0] int_en;

    // apb decode
    logic setup;
    logic access;
    logic hit_cfg;
    logic hit_stat;
    logic hit_en;
    logic hit_clr;
    logic hit_live;
    logic hit_any;
    logic wr_cfg;
    logic wr_en;
    logic wr_clr;
    logic [31:0] wmask;
    logic [31:0] next_cfg;
    logic [`ILD_ST_W-1:0] next_stat;
    logic [`ILD_ST_W-1:0] next_en;
    logic [31:0] live;
    logic [31:0] rd_mux;

    // slot side
    ild_pkg::slot_cfg_t [3:0] slot_cfg;
    logic [3:0] slot_dma [0:3];
    logic [3:0] mode_warn;
    logic [3:0] bad_wr;
    logic [3:0] dma_fire;
    logic [3:0] overrun;
    logic [3:0] next_dma;
    logic [`ILD_ST_W-1:0] events;
    logic dma_route_src20;
    logic dma_route_src21;
    logic dma_route_src22;
    logic dma_route_src23;

    // address match shared by every register
    function automatic logic addr_is(input logic [31:0] a, input logic [31:0] reg_addr);
        return a == reg_addr;
    endfunction

    // the slave answers in the first access cycle, so pready is tied high
    assign PREADY = 1'b1;
    assign setup = PSEL & ~PENABLE;
    assign access = PSEL & PENABLE;
    assign hit_cfg = addr_is(PADDR, `ILD_CFG_ADDR);
    assign hit_stat = addr_is(PADDR, `ILD_STAT_ADDR);
    assign hit_en = addr_is(PADDR, `ILD_EN_ADDR);
    assign hit_clr = addr_is(PADDR, `ILD_CLR_ADDR);
    assign hit_live = addr_is(PADDR, `ILD_LIVE_ADDR);
    assign hit_any = hit_cfg | hit_stat | hit_en | hit_clr | hit_live;
    // unmapped addresses answer with an error and change nothing
    assign PSLVERR = access & ~hit_any;
    assign wr_cfg = access & PWRITE & hit_cfg;
    assign wr_en = access & PWRITE & hit_en;
    assign wr_clr = access & PWRITE & hit_clr;

    // byte strobes widened to a bit mask, one lane per slot
    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_lane
            assign wmask[b*8 +: 8] = {8{PSTRB[b]}};
        end
    endgenerate

    // unused slot bits are never stored, so they read back as zero
    assign next_cfg = ((cfg & ~wmask) | (PWDATA & wmask)) & `ILD_CFG_MASK;

    // named route bits at their fixed positions
    assign dma_route_src20 = cfg[`ILD_SRC20_DMA];
    assign dma_route_src21 = cfg[`ILD_SRC21_DMA];
    assign dma_route_src22 = cfg[`ILD_SRC22_DMA];
    assign dma_route_src23 = cfg[`ILD_SRC23_DMA];

    // enable register covers the same layout as status, in the low bits
    assign next_en = PWDATA[`ILD_ST_W-1:0];

    // configuration register
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            cfg <= `ILD_CFG_RST;
        end else if (wr_cfg) begin
            cfg <= next_cfg;
        end
    end

    // interrupt enable register
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            int_en <= `ILD_ST_RST;
        end else if (wr_en) begin
            int_en <= next_en;
        end
    end

    // one slot per byte lane: lane k serves source 20 plus k
    genvar k;
    generate
        for (k = 0; k < `ILD_NSLOT; k++) begin : g_slot
            assign slot_cfg[k] = ild_pkg::slot_cfg_t'(cfg[k*`ILD_SLOT_W +: `ILD_SLOT_W]);
            // an invalid selector written with routing set is flagged, not stored as a channel
            assign bad_wr[k] = wr_cfg & PSTRB[k] & PWDATA[k*8 + `ILD_DMA_BIT] & PWDATA[k*8 + 2];
            ild_slot u_slot (
                .clk(CORE_CLK),
                .rst_n(RST_N),
                .src(SRC_IRQ[k]),
                .cfg(slot_cfg[k]),
                .irq(IRQ_OUT[k]),
                .dma_ch(slot_dma[k]),
                .mode_warn(mode_warn[k])
            );
        end
    endgenerate

    // several sources may share a channel; their triggers merge into one request
    assign dma_fire = slot_dma[0] | slot_dma[1] | slot_dma[2] | slot_dma[3];
    // a trigger landing on a request still waiting for its ack is an overrun
    assign overrun = dma_fire & DMA_REQ & ~DMA_ACK;
    // a new trigger in the ack cycle keeps the request up
    assign next_dma = (DMA_REQ & ~DMA_ACK) | dma_fire;

    // dma request held until the controller acknowledges it
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            DMA_REQ <= 4'h0;
        end else begin
            DMA_REQ <= next_dma;
        end
    end

    // event vector in status layout
    assign events = {overrun, mode_warn, bad_wr};
    // set wins over a clear written in the same cycle
    assign next_stat = (stat & ~(wr_clr ? PWDATA[`ILD_ST_W-1:0] : `ILD_ST_RST)) | events;

    // sticky status register
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            stat <= `ILD_ST_RST;
        end else begin
            stat <= next_stat;
        end
    end

    // level interrupt from the enabled flags, registered for a clean output
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            INT_OUT <= 1'b0;
        end else begin
            INT_OUT <= |(next_stat & int_en);
        end
    end

    // live view: pending dma requests, interrupt requests and route bits
    assign live = {20'h00000, DMA_REQ,
                   IRQ_OUT[3].req, IRQ_OUT[2].req, IRQ_OUT[1].req, IRQ_OUT[0].req,
                   dma_route_src23, dma_route_src22, dma_route_src21, dma_route_src20};

    // read selection; the clear register and unmapped space read zero
    assign rd_mux = hit_cfg ? cfg :
                    hit_stat ? {20'h00000, stat} :
                    hit_en ? {20'h00000, int_en} :
                    hit_live ? live : 32'h00000000;

    // read data captured in the setup cycle and held through the access
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            PRDATA <= 32'h00000000;
        end else if (setup) begin
            PRDATA <= PWRITE ? 32'h00000000 : rd_mux;
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_cfg_wr_lane1;
        access && PWRITE && hit_cfg && PSTRB[1];
    endsequence

    sequence s_cfg_wr_lane0;
        access && PWRITE && hit_cfg && PSTRB[0];
    endsequence

    sequence s_cfg_wr_lane23;
        access && PWRITE && hit_cfg && PSTRB[2] && PSTRB[3];
    endsequence

    AST_SRC21_ROUTE_BIT: assert property (s_cfg_wr_lane1 |=>
        dma_route_src21 == $past(PWDATA[11]))
        else $error("source 21 route bit not at position 11");
    AST_SRC20_SLOT: assert property (s_cfg_wr_lane0 |=>
        slot_cfg[0].sel == $past(PWDATA[2:0]) && slot_cfg[0].dma == $past(PWDATA[3]))
        else $error("source 20 slot not at bits 7 to 0");
    AST_SRC22_23_SLOT: assert property (s_cfg_wr_lane23 |=>
        slot_cfg[2].dma == $past(PWDATA[19]) && slot_cfg[3].sel == $past(PWDATA[26:24]))
        else $error("source 22 or 23 slot misplaced");
    AST_RESET_CLEAR: assert property (@(posedge CORE_CLK) $rose(RST_N) |-> cfg == 32'h00000000 && DMA_REQ == 4'h0)
        else $error("state not cleared by reset");
    AST_UNUSED_ZERO: assert property ((cfg & ~`ILD_CFG_MASK) == 32'h00000000)
        else $error("unused configuration bits read nonzero");
    AST_BAD_SEL_FLAG: assert property (|bad_wr |=> |stat[3:0])
        else $error("invalid selector write not flagged");
    AST_SET_WINS: assert property (|events && wr_clr |=> (stat & $past(events)) == $past(events))
        else $error("event lost against a clear");
    AST_DMA_HOLD: assert property (DMA_REQ[0] && !DMA_ACK[0] |=> DMA_REQ[0][*2] or (DMA_REQ[0] ##1 DMA_ACK[0] || !DMA_REQ[0]))
        else $error("dma request dropped before ack");
    AST_INT_LEVEL: assert property (|(stat & int_en) && !wr_clr && !wr_en |=> INT_OUT)
        else $error("enabled flag did not raise the interrupt");

endmodule
`default_nettype wire

// ==== testbench/ild_far.sv ====
// dma controller model: acknowledges each channel request after a set delay
`default_nettype none
module ild_far (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] dma_req,
    input wire logic [1:0] ack_dly,
    output var logic [3:0] dma_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt [4];
    // one ack pulse per request, never while idle, as a real controller does
    always_ff @(posedge clk) begin
        for (int c = 0; c < 4; c++) begin
            if (!rst_n || !dma_req[c] || dma_ack[c]) begin
                cnt[c] <= 2'h0;
                dma_ack[c] <= 1'b0;
            end else if (cnt[c] == ack_dly) begin
                dma_ack[c] <= 1'b1;
            end else begin
                cnt[c] <= cnt[c] + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/irq_level_dma_route_slots_test.sv ====
// self-checking bench for the level and dma routing block
`include "ild_defs.svh"
`default_nettype none
module irq_level_dma_route_slots_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [3:0] src = 4'h0;
    logic [1:0] ack_dly = 2'h0;
    logic [31:0] prdata;
    wire logic pready;
    wire logic pslverr;
    ild_pkg::slot_out_t [3:0] irq_out;
    logic [3:0] dma_req;
    logic [3:0] dma_ack;
    logic [3:0] prev_dma = 4'h0;
    logic int_out;
    logic [31:0] rnd = 32'h5c82;
    logic [31:0] v;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [32:0] rd_q[$];
    logic [3:0] dma_q[$];
    logic [5:0] irq_q[$];

    always #25 core_clk = ~core_clk;

    ild_top dut (.CORE_CLK(core_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .SRC_IRQ(src), .IRQ_OUT(irq_out),
        .DMA_REQ(dma_req), .DMA_ACK(dma_ack), .INT_OUT(int_out));
    ild_far far (.clk(core_clk), .rst_n(rst_n), .dma_req(dma_req), .ack_dly(ack_dly),
        .dma_ack(dma_ack));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string name, input logic [32:0] exp, input logic [32:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic final_report;
        if (err_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // one apb transfer; the expected {pslverr, prdata} is noted at setup
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
        input logic [32:0] ex);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        rd_q.push_back(ex);
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0, {1'b0, ex});
    endtask

    // one-cycle source pulse, then room for the dma handshake to finish
    task automatic pulse(input int k);
        @(posedge core_clk);
        src[k] <= 1'b1;
        @(posedge core_clk);
        src[k] <= 1'b0;
        repeat (10) @(posedge core_clk);
    endtask

    task automatic settle;
        @(posedge core_clk);
        @(negedge core_clk);
    endtask

    // result watcher: oldest note is compared whenever a result shows up
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        prev_dma <= dma_req;
        if (psel && penable && pready) begin
            chk("apb", rd_q.size() > 0 ? rd_q.pop_front() : '1, {pslverr, prdata});
        end
        if ((dma_req & ~prev_dma) != 4'h0) begin
            chk("dma", dma_q.size() > 0 ? dma_q.pop_front() : 4'h0, dma_req & ~prev_dma);
        end
        for (int k = 0; k < 4; k++) begin
            if (irq_out[k].req === 1'b1) begin
                chk("irq", irq_q.size() > 0 ? irq_q.pop_front() : 6'h3f,
                    {1'b0, 2'(k), irq_out[k].level});
            end
        end
        // hang guard, far above the length of the sequence
        if (cyc == 30000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(`ILD_CFG_ADDR, 32'h0);
        rd(`ILD_STAT_ADDR, 32'h0);
        wr(`ILD_CFG_ADDR, 32'hffffffff);
        rd(`ILD_CFG_ADDR, 32'h3f3f3f3f);
        wr(`ILD_CFG_ADDR, 32'h0);
        pstrb <= 4'h2;
        wr(`ILD_CFG_ADDR, 32'hffffffff);
        pstrb <= 4'hf;
        rd(`ILD_CFG_ADDR, 32'h00003f00);
        // the all-ones writes set routing with selector 111 on every lane
        rd(`ILD_STAT_ADDR, 32'hf);
        wr(`ILD_CLR_ADDR, 32'hfff);
        rd(`ILD_STAT_ADDR, 32'h0);
        apb(1'b0, 32'hffffe200, 32'h0, {1'b1, 32'h0});
        // every level on every slot, trigger mode written first
        for (int k = 0; k < 4; k++) begin
            for (int f = 0; f < 8; f++) begin
                v = 32'h30 << (8 * k);
                wr(`ILD_CFG_ADDR, v);
                v = v | (f << (8 * k));
                wr(`ILD_CFG_ADDR, v);
                rd(`ILD_CFG_ADDR, v);
                settle();
                chk("level", f, irq_out[k].level);
                if (f != 0) begin
                    irq_q.push_back({1'b0, 2'(k), 3'(f)});
                end
                pulse(k);
            end
        end
        // every channel on every slot, random ack delay from the partner
        for (int k = 0; k < 4; k++) begin
            for (int c = 0; c < 4; c++) begin
                v = 32'h30 << (8 * k);
                wr(`ILD_CFG_ADDR, v);
                v = v | ((32'h8 | c) << (8 * k));
                wr(`ILD_CFG_ADDR, v);
                settle();
                chk("level", 0, irq_out[k].level);
                dma_q.push_back(4'h1 << c);
                rnd = lfsr(rnd);
                ack_dly <= rnd[1:0];
                pulse(k);
            end
        end
        // invalid selector on purpose: no dma, status flag raises the interrupt
        wr(`ILD_EN_ADDR, 32'h1);
        rd(`ILD_EN_ADDR, 32'h1);
        wr(`ILD_CFG_ADDR, 32'h30);
        wr(`ILD_CFG_ADDR, 32'h3c);
        pulse(0);
        rd(`ILD_STAT_ADDR, 32'h1);
        settle();
        chk("int", 1, int_out);
        wr(`ILD_EN_ADDR, 32'h0);
        settle();
        chk("int", 0, int_out);
        wr(`ILD_EN_ADDR, 32'h1);
        wr(`ILD_STAT_ADDR, 32'hffffffff);
        rd(`ILD_STAT_ADDR, 32'h1);
        wr(`ILD_CLR_ADDR, 32'h1);
        settle();
        chk("int", 0, int_out);
        rd(`ILD_STAT_ADDR, 32'h0);
        repeat (10) @(posedge core_clk);
        chk("pending", 0, rd_q.size() + dma_q.size() + irq_q.size());
        final_report();
    end
endmodule
`default_nettype wire
